// >>> pkg/rfa_regs.vh
// register offsets, field widths and reset values of the field-type demonstration bank
`ifndef RFA_REGS_VH
`define RFA_REGS_VH
`define RFA_DW 32
`define RFA_AW 12
`define RFA_OFF_RW 12'h000
`define RFA_OFF_RO 12'h004
`define RFA_OFF_RC 12'h008
`define RFA_OFF_RWC 12'h00c
`define RFA_OFF_RW1C 12'h010
`define RFA_OFF_W1C 12'h014
`define RFA_OFF_RW1S 12'h018
`define RFA_RST_RW 32'h0000_0000
`define RFA_RST_RO 32'h0000_0000
`define RFA_RST_STAT 32'h0000_0000
`define RFA_RST_RW1S 32'h0000_0000
`define RFA_RSVD_MASK_RW 32'hffff_ffff
`define RFA_WO_READ 32'h0000_0000
`endif

// >>> logic/rfa_field.v
// one register of configurable field type
`timescale 1ns/1ps
module rfa_field #(
  parameter integer DW = 32,
  parameter [2:0] KIND = 3'h0,
  parameter [DW-1:0] RST = {DW{1'b0}},
  parameter [DW-1:0] MASK = {DW{1'b1}}
) (
  clock,
  rst,
  wr,
  rd,
  wdata,
  hw_set,
  hw_val,
  value
);
  input wire clock;
  input wire rst;
  input wire wr;
  input wire rd;
  input wire [DW-1:0] wdata;
  input wire [DW-1:0] hw_set;
  input wire [DW-1:0] hw_val;
  output wire [DW-1:0] value;
  // kinds: 0 rw, 1 ro, 2 rc, 3 rwc, 4 rw1c, 5 w1c, 6 rw1s
  reg [DW-1:0] val_ff;
  reg [DW-1:0] nxt_val;
  always @* begin
    nxt_val = val_ff;
    case (KIND)
      3'h0: if (wr) nxt_val = wdata & MASK;
      3'h1: nxt_val = hw_val;
      3'h2: if (rd) nxt_val = {DW{1'b0}};
      3'h3: if (wr) nxt_val = {DW{1'b0}};
      3'h4: if (wr) nxt_val = val_ff & ~wdata;
      3'h5: if (wr) nxt_val = val_ff & ~wdata;
      3'h6: if (wr) nxt_val = val_ff | wdata;
      default: nxt_val = val_ff;
    endcase
    // hardware events win over a clear in the same cycle
    if (KIND >= 3'h2 && KIND <= 3'h5) nxt_val = nxt_val | hw_set;
  end
  always @(posedge clock) begin
    if (rst) val_ff <= RST;
    else val_ff <= nxt_val;
  end
  assign value = val_ff;
endmodule

// >>> logic/rfa_bank.v
// register bank showing each field access type behind a simple register port
`timescale 1ns/1ps
`include "rfa_regs.vh"
module rfa_bank #(
  parameter [`RFA_AW-1:0] BASE = 12'h000
) (
  clock,
  rst,
  reg_sel,
  reg_wr,
  reg_addr,
  reg_wdata,
  reg_rdata,
  reg_rvalid,
  reg_err,
  hw_status,
  hw_ro_val,
  ctrl_out,
  set_out
);
  input wire clock;
  input wire rst;
  input wire reg_sel;
  input wire reg_wr;
  input wire [`RFA_AW-1:0] reg_addr;
  input wire [`RFA_DW-1:0] reg_wdata;
  output reg [`RFA_DW-1:0] reg_rdata;
  output reg reg_rvalid;
  output reg reg_err;
  input wire [`RFA_DW-1:0] hw_status;
  input wire [`RFA_DW-1:0] hw_ro_val;
  output reg [`RFA_DW-1:0] ctrl_out;
  output reg [`RFA_DW-1:0] set_out;
  ////////////////////////////////////////////////////////////////////////////
  // address decode relative to the base
  function hit;
    input [`RFA_AW-1:0] addr;
    input [`RFA_AW-1:0] off;
    begin
      hit = (addr == BASE + off);
    end
  endfunction
  wire wr_en = reg_sel & reg_wr;
  wire rd_en = reg_sel & ~reg_wr;
  wire [6:0] sel;
  assign sel[0] = hit(reg_addr, `RFA_OFF_RW);
  assign sel[1] = hit(reg_addr, `RFA_OFF_RO);
  assign sel[2] = hit(reg_addr, `RFA_OFF_RC);
  assign sel[3] = hit(reg_addr, `RFA_OFF_RWC);
  assign sel[4] = hit(reg_addr, `RFA_OFF_RW1C);
  assign sel[5] = hit(reg_addr, `RFA_OFF_W1C);
  assign sel[6] = hit(reg_addr, `RFA_OFF_RW1S);
  ////////////////////////////////////////////////////////////////////////////
  // one register per field type
  wire [`RFA_DW*7-1:0] vals;
  genvar g;
  generate
    for (g = 0; g < 7; g = g + 1) begin : regs
      localparam integer GI = g;
      rfa_field #(
        .DW(`RFA_DW),
        .KIND(GI[2:0]),
        .RST(g == 6 ? `RFA_RST_RW1S : g == 0 ? `RFA_RST_RW : `RFA_RST_STAT),
        .MASK(`RFA_RSVD_MASK_RW)
      ) u_fld (
        .clock(clock),
        .rst(rst),
        .wr(wr_en & sel[g]),
        .rd(rd_en & sel[g]),
        .wdata(reg_wdata),
        .hw_set(hw_status),
        .hw_val(hw_ro_val),
        .value(vals[g*`RFA_DW +: `RFA_DW])
      );
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////////
  // read mux; read data is the value before any read side effect
  reg [`RFA_DW-1:0] nxt_rdata;
  reg nxt_err;
  integer i;
  always @* begin
    nxt_rdata = {`RFA_DW{1'b0}};
    nxt_err = reg_sel & ~(|sel);
    for (i = 0; i < 7; i = i + 1) begin
      if (sel[i] && i != 5) nxt_rdata = nxt_rdata | vals[i*`RFA_DW +: `RFA_DW];
    end
    if (sel[5]) nxt_rdata = `RFA_WO_READ;
  end
  always @(posedge clock) begin
    if (rst) begin
      reg_rdata <= {`RFA_DW{1'b0}};
      reg_rvalid <= 1'b0;
      reg_err <= 1'b0;
      ctrl_out <= `RFA_RST_RW;
      set_out <= `RFA_RST_RW1S;
    end else begin
      reg_rvalid <= reg_sel;
      reg_err <= nxt_err;
      reg_rdata <= rd_en ? nxt_rdata : {`RFA_DW{1'b0}};
      ctrl_out <= vals[0*`RFA_DW +: `RFA_DW];
      set_out <= vals[6*`RFA_DW +: `RFA_DW];
    end
  end
endmodule

// >>> verification/rfa_bank_chk.sv
// port assertions of the field-type bank
`timescale 1ns/1ps
module rfa_bank_chk #(parameter [11:0] BASE = 12'h000) (
  input wire clock, input wire rst, input wire reg_sel, input wire reg_wr,
  input wire [11:0] reg_addr, input wire [31:0] reg_wdata, input wire [31:0] reg_rdata,
  input wire reg_rvalid, input wire reg_err, input wire [31:0] hw_status,
  input wire [31:0] ctrl_out, input wire [31:0] set_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire rd = reg_sel && !reg_wr;
  wire wrq = reg_sel && reg_wr;
  wire q = !reg_sel && hw_status == 32'h0;
  wire a_rc = reg_addr == BASE + 12'h008;
  wire a_rwc = reg_addr == BASE + 12'h00c;
  chk_answer_next: assert property (reg_sel |=> reg_rvalid) else $error("no answer");
  chk_err_zero: assert property (reg_err |-> reg_rdata == 32'h0) else $error("error data");
  chk_rc_clear: assert property (rd && a_rc && hw_status == 32'h0 ##1 q ##1 rd && a_rc && hw_status == 32'h0
    |=> reg_rdata == 32'h0) else $error("rc kept");
  chk_rwc_clear: assert property (wrq && a_rwc && hw_status == 32'h0 ##1 q ##1 rd && a_rwc && hw_status == 32'h0
    |=> reg_rdata == 32'h0) else $error("rwc kept");
  chk_w1c_read: assert property (rd && reg_addr == BASE + 12'h014 |=> reg_rdata == 32'h0) else $error("w1c");
  chk_rw_copy: assert property (wrq && reg_addr == BASE |=> ##1 ctrl_out == $past(reg_wdata, 2)) else $error("rw");
  chk_w1s_set: assert property (wrq && reg_addr == BASE + 12'h018 |=> ##1
    (set_out & $past(reg_wdata, 2)) == $past(reg_wdata, 2)) else $error("w1s set");
  chk_w1s_keep: assert property (($past(set_out) & ~set_out) == 32'h0) else $error("w1s fell");
  chk_rst_zero: assert property (disable iff (1'b0) rst |=> ctrl_out == 32'h0 && set_out == 32'h0)
    else $error("reset");
endmodule
bind rfa_bank rfa_bank_chk #(.BASE(BASE)) i_rfa_bank_chk(.*);

// >>> verification/rfa_hw_model.sv
// hardware event source beside the bank
`timescale 1ns/1ps
module rfa_hw_model #(parameter [31:0] RO = 32'h0000_5a5a) (
  input wire clock,
  input wire [31:0] ev,
  output reg [31:0] hw_status = 32'h0,
  output wire [31:0] hw_ro_val
);
  always @(posedge clock) hw_status <= ev;
  assign hw_ro_val = RO;
endmodule

// >>> verification/rfa_bank_test.sv
// random and corner tests of the field-type bank
`timescale 1ns/1ps
module rfa_bank_test;
  reg clock = 0, rst = 1, sel = 0, wr = 0;
  reg [11:0] addr = 12'h0;
  reg [31:0] wd = 32'h0, ev = 32'h0, v, w, r;
  wire [31:0] rdata, hs, ro, ctrl, so;
  wire rv, err;
  integer miscompares = 0, check_count = 0, seed = 32'hfbf69756, cyc = 0;
  always #10 clock = ~clock;
  rfa_hw_model i_rfa_hw_model(.clock(clock), .ev(ev), .hw_status(hs), .hw_ro_val(ro));
  rfa_bank i_rfa_bank(.clock(clock), .rst(rst), .reg_sel(sel), .reg_wr(wr), .reg_addr(addr), .reg_wdata(wd),
    .reg_rdata(rdata), .reg_rvalid(rv), .reg_err(err), .hw_status(hs), .hw_ro_val(ro), .ctrl_out(ctrl),
    .set_out(so));
  task chk(input [39:0] n, input [31:0] e, input [31:0] g); begin
    check_count = check_count + 1;
    if (g !== e) begin
      miscompares = miscompares + 1;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  end endtask
  task acc(input x, input [11:0] a, input [31:0] d); begin
    @(posedge clock) sel <= 1'b1;
    wr <= x;
    addr <= a;
    wd <= d;
    @(posedge clock) sel <= 1'b0;
    #1 r = rdata;
  end endtask
  task finish_test; begin
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  end endtask
  always @(posedge clock) begin
    cyc = cyc + 1;
    if (cyc == 500) begin
      miscompares = miscompares + 1;
      finish_test;
    end
  end
  initial begin
    v = $random(seed);
    w = $random(seed);
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    acc(0, 12'h000, 32'h0); chk("rdata", 32'h0, r);
    acc(1, 12'h000, v); acc(0, 12'h000, 32'h0); chk("rdata", v, r);
    chk("ctrl", v, ctrl);
    acc(1, 12'h000, r); acc(0, 12'h000, 32'h0); chk("rdata", v, r);
    @(posedge clock) ev <= v;
    @(posedge clock) ev <= 32'h0;
    acc(0, 12'h008, 32'h0); chk("rdata", v, r);
    acc(0, 12'h008, 32'h0); chk("rdata", 32'h0, r);
    acc(0, 12'h00c, 32'h0); chk("rdata", v, r);
    acc(1, 12'h00c, w); acc(0, 12'h00c, 32'h0); chk("rdata", 32'h0, r);
    acc(1, 12'h010, w); acc(0, 12'h010, 32'h0); chk("rdata", v & ~w, r);
    acc(1, 12'h014, w); acc(0, 12'h014, 32'h0); chk("rdata", 32'h0, r);
    acc(1, 12'h018, v); acc(1, 12'h018, w); acc(0, 12'h018, 32'h0); chk("rdata", v | w, r);
    chk("seto", v | w, so);
    acc(1, 12'h004, 32'h0); acc(0, 12'h004, 32'h0); chk("rdata", ro, r);
    acc(0, 12'h020, 32'h0); chk("err", 32'h1, {31'h0, err});
    chk("rvld", 32'h1, {31'h0, rv});
    $display("field type sequence done");
    finish_test;
  end
endmodule
